// ---- hw/plc_engine.sv ----
/*
   programmable logic engine: unit settings, point bank, unit walk,
   sequencer and two selectors, all behind a classic wishbone slave.
   assumes a 20 MHz clock; control side shares the bank via the bus.
*/
// The address map and the Wishbone interface to the registers were decided locally.
`default_nettype none
`include "plc_cfg.svh"
module plc_engine
   import plc_pkg::*;
#(
   parameter int TENTH_CYC = `TENTH_TIME_MS * 1000 * `CLK_MHZ
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic      [7:0]  phase_onehot,
   output logic      [2:0]  phase_index_out,
   output logic             engine_enable
);
   localparam int SLOT_CYC = `SLOT_TIME_US * `CLK_MHZ;

   ////////////////////////////////////////////////////////////////////////
   // registers and bus slave

   logic [7:0]    active_count;
   logic [3:0]    sequence_length;
   logic [5:0]    exec_rank_one;
   logic [5:0]    exec_rank_two;
   logic          bus_busy;
   logic [1:0]    bus_region;
   logic [2:0]    bus_reg;
   engine_state_t state;
   logic [7:0]    slot;
   logic          seq_active;
   logic [15:0]   cfg_rd;
   logic [15:0]   pt_rd;

   wire       bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !bus_busy;
   wire       quiet     = (state == S_IDLE) || (state == S_WAIT);
   wire       bus_start = bus_req && quiet;
   wire       lanes_ok  = wb_sel_i[1:0] == 2'b11;
   wire       bus_wr    = bus_start && wb_we_i && lanes_ok;
   wire [1:0] region    = wb_adr_i[11:10];
   wire       reg_wr    = bus_wr && region == 2'b01;
   wire [2:0] reg_idx   = wb_adr_i[4:2];
   wire       reg_hole  = |wb_adr_i[9:5];

   wire [15:0] reg_rd =
      (bus_reg == `REG_CTRL)   ? {15'h0000, engine_enable} :
      (bus_reg == `REG_COUNT)  ? {8'h00, active_count} :
      (bus_reg == `REG_LEN)    ? {12'h000, sequence_length} :
      (bus_reg == `REG_RANK1)  ? {10'h000, exec_rank_one} :
      (bus_reg == `REG_RANK2)  ? {10'h000, exec_rank_two} :
      (bus_reg == `REG_STATUS) ? {slot, 3'h0, quiet, seq_active, phase_index_out} :
      16'h0000;

   wire [15:0] bus_rd =
      (bus_region == 2'b00) ? cfg_rd :
      (bus_region == 2'b01) ? reg_rd :
      (bus_region[1])       ? pt_rd : 16'h0000;

   // rank is kept for software; evaluation order already follows the host unit
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         engine_enable   <= 1'b0;
         active_count    <= `RST_COUNT;
         sequence_length <= `RST_LEN;
         exec_rank_one   <= `RST_RANK;
         exec_rank_two   <= `RST_RANK;
      end else if (reg_wr && !reg_hole) begin
         unique case (reg_idx)
            `REG_CTRL:   engine_enable   <= wb_dat_i[0];
            `REG_COUNT:  active_count    <= wb_dat_i[7:0];
            `REG_LEN:    sequence_length <= wb_dat_i[3:0];
            `REG_RANK1:  exec_rank_one   <= wb_dat_i[5:0];
            `REG_RANK2:  exec_rank_two   <= wb_dat_i[5:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_busy   <= 1'b0;
         bus_region <= 2'b00;
         bus_reg    <= 3'h7;
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= 32'h0000_0000;
      end else begin
         wb_ack_o <= 1'b0;
         if (bus_start) begin
            bus_busy   <= 1'b1;
            bus_region <= region;
            bus_reg    <= reg_hole ? 3'h7 : reg_idx;
         end else if (bus_busy) begin
            bus_busy <= 1'b0;
            wb_ack_o <= 1'b1;
            wb_dat_o <= {16'h0000, bus_rd};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // slot timer and tenth-second tick

   logic [11:0] slot_cnt;
   logic [31:0] tick_cnt;
   logic        tick;

   wire slot_done = slot_cnt == 12'(SLOT_CYC - 1);
   wire advance   = (state == S_WAIT) && slot_done && !bus_busy && !bus_req;
   wire [7:0] next_slot = (8'(slot + 8'h01) >= active_count) ? 8'h00 : 8'(slot + 8'h01);

   // the slot counter parks at its end, so a bus wait only stretches a slot
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         slot_cnt <= 12'h000;
      end else if (state == S_IDLE || advance) begin
         slot_cnt <= 12'h000;
      end else if (!slot_done) begin
         slot_cnt <= 12'(slot_cnt + 12'h001);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_cnt <= 32'h0000_0000;
         tick     <= 1'b0;
      end else begin
         tick     <= tick_cnt == 32'(TENTH_CYC - 1);
         tick_cnt <= (tick_cnt == 32'(TENTH_CYC - 1)) ? 32'h0000_0000 :
                     32'(tick_cnt + 32'h0000_0001);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // unit walk

   logic [5:0]   unit;
   logic [5:0]   fn;
   logic [2:0]   op_idx;
   logic [15:0]  ops [0:6];
   logic [15:0]  result;
   logic [15:0]  calc;
   logic [2:0]   seq_phase;
   logic [7:0]   seq_onehot;

   wire is_seq  = fn == `FN_SEQ;
   wire is_sel  = fn == `FN_SEL1 || fn == `FN_SEL2;
   wire [7:0] sel_base = (fn == `FN_SEL1) ? `CFG_SEL1_BASE : `CFG_SEL2_BASE;
   wire [7:0] unit_cfg = {unit, 2'b00};

   wire [7:0] op_cfg_addr =
      is_seq ? ((op_idx == 3'h0) ? `CFG_SEQ_BASE :
                (op_idx == 3'h1) ? 8'(`CFG_SEQ_BASE + 8'h01 + {5'h00, seq_phase}) :
                8'(`CFG_SEQ_BASE + `SEQ_NEXT_OFS + {5'h00, op_idx})) :
      is_sel ? ((op_idx == 3'h3) ? 8'(sel_base + 8'h03 + {5'h00, ops[1][2:0]}) :
                8'(sel_base + {5'h00, op_idx})) :
      8'(unit_cfg + 8'h01 + {5'h00, op_idx});

   wire [2:0] last_idx = is_seq ? 3'h6 : is_sel ? 3'h3 : 3'h2;
   wire [5:0] new_fn   = cfg_rd[5:0];
   wire       has_ops  = (new_fn >= `FN_ADD && new_fn <= `FN_SWITCH) ||
                         new_fn == `FN_SEQ || new_fn == `FN_SEL1 || new_fn == `FN_SEL2;

   wire signed [15:0] op_a = ops[0];
   wire signed [15:0] op_b = ops[1];
   wire signed [15:0] op_c = ops[2];
   wire signed [31:0] prod = op_a * op_b;
   wire signed [31:0] div  = {{16{op_c[15]}}, op_c};
   wire signed [31:0] quo  = (op_c == 16'sh0000) ? 32'sh0000_0000 : prod / div;

   always_comb begin
      unique case (fn)
         `FN_ADD:    calc = 16'(op_a + op_b);
         `FN_MULDIV: calc = quo[15:0];
         `FN_SUB:    calc = 16'(op_a - op_b);
         `FN_AND:    calc = {15'h0000, op_a != 16'sh0000 && op_b != 16'sh0000};
         `FN_OR:     calc = {15'h0000, op_a != 16'sh0000 || op_b != 16'sh0000};
         `FN_NOT:    calc = {15'h0000, op_a == 16'sh0000};
         `FN_GT:     calc = {15'h0000, op_a > op_b};
         `FN_SWITCH: calc = (op_c != 16'sh0000) ? ops[0] : ops[1];
         `FN_SEL1,
         `FN_SEL2:   calc = (ops[0] != 16'h0000) ? ops[3] : ops[2];
         default:    calc = 16'h0000;
      endcase
   end

   wire [15:0] seq_num  = seq_active ? {13'h0000, 3'(seq_phase + 3'h1)} : 16'h0000;
   wire [15:0] wr_val   = is_seq ? seq_num : result;
   wire [8:0]  extra_pt = is_seq ? `PT_SEQ : (fn == `FN_SEL1) ? `PT_SEL1 : `PT_SEL2;
   wire [8:0]  unit_pt  = 9'(`PT_UNIT_BASE + {3'h0, unit});
   wire        seq_eval = (state == S_CALC) && is_seq;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state  <= S_IDLE;
         unit   <= 6'h00;
         slot   <= 8'h00;
         fn     <= 6'h00;
         op_idx <= 3'h0;
         result <= 16'h0000;
      end else if (!engine_enable) begin
         state <= S_IDLE;
         slot  <= 8'h00;
         unit  <= 6'h00;
      end else begin
         unique case (state)
            S_IDLE: if (!bus_busy && !bus_req) begin
               state <= S_FN;
            end
            S_FN: state <= S_FN_GET;
            S_FN_GET: begin
               fn     <= new_fn;
               op_idx <= 3'h0;
               state  <= has_ops ? S_PTR : S_CALC;
            end
            S_PTR:     state <= S_PTR_GET;
            S_PTR_GET: state <= S_PT_GET;
            S_PT_GET: begin
               op_idx <= 3'(op_idx + 3'h1);
               state  <= (op_idx == last_idx) ? S_CALC : S_PTR;
            end
            S_CALC: begin
               result <= calc;
               state  <= S_WR;
            end
            S_WR:  state <= (is_seq || is_sel) ? S_WR2 : S_WAIT;
            S_WR2: state <= S_WAIT;
            S_WAIT: if (advance) begin
               slot  <= next_slot;
               unit  <= next_slot[5:0];
               state <= (next_slot < `UNIT_COUNT) ? S_FN : S_WAIT;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // operand capture is kept apart so the walk above stays readable
   always_ff @(posedge clk) begin
      if (state == S_PT_GET) begin
         ops[op_idx] <= pt_rd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // memories: settings words and point bank

   wire        cfg_we   = bus_wr && region == 2'b00;
   wire [7:0]  cfg_addr = bus_start ? wb_adr_i[9:2] :
                          (state == S_FN) ? unit_cfg : op_cfg_addr;
   wire        eng_pt_we = state == S_WR || state == S_WR2;
   wire        pt_we    = (bus_wr && region[1]) || eng_pt_we;
   wire [8:0]  pt_addr  = bus_start ? wb_adr_i[10:2] :
                          (state == S_WR)  ? unit_pt :
                          (state == S_WR2) ? extra_pt : cfg_rd[8:0];
   wire [15:0] pt_wdata = bus_start ? wb_dat_i[15:0] : wr_val;

   plc_mem #(.AW(8), .DW(16)) settings_mem (
      .clk   (clk),
      .we    (cfg_we),
      .addr  (cfg_addr),
      .wdata (wb_dat_i[15:0]),
      .rdata (cfg_rd)
   );

   plc_mem #(.AW(9), .DW(16)) point_bank (
      .clk   (clk),
      .we    (pt_we),
      .addr  (pt_addr),
      .wdata (pt_wdata),
      .rdata (pt_rd)
   );

   ////////////////////////////////////////////////////////////////////////
   // sequencer

   plc_sequencer sequencer (
      .clk               (clk),
      .sys_rst           (sys_rst),
      .tick              (tick),
      .eval              (seq_eval),
      .seq_on            (ops[0] != 16'h0000),
      .time_val          (ops[1]),
      .step_fwd          (ops[2] != 16'h0000),
      .step_back         (ops[3] != 16'h0000),
      .force_first_phase (ops[4] != 16'h0000),
      .force_load        (ops[5] != 16'h0000),
      .load_phase_value  (ops[6][2:0]),
      .sequence_length   (sequence_length),
      .phase_index_out   (seq_phase),
      .phase_onehot      (seq_onehot),
      .seq_active        (seq_active)
   );

   assign phase_index_out = seq_phase;
   assign phase_onehot    = seq_onehot;
endmodule
`default_nettype wire

// ---- include/plc_cfg.svh ----
/*
   constants of the logic engine: map, codes, reset values, timing.
   assumes a 20 MHz clock and 16-bit point values.
*/
// Operation
// - units run only while the engine enable bit is set
// - 48 units, three inputs each, function chosen by code
// - unit n result goes to point 255+n, points 256 to 303
// - unit n settings: code, input a, b, c at words 4(n-1) onward
// - units run in ascending order within a cycle
// - cycle period is active count times 0.2 ms, count resets to 50
// - units above the active count are skipped
// - sequencer and selectors act only when hosted by a unit
// - sequencer ignores a, b, c; number goes to host point and 312
// - sequencer disabled forces outputs zero; enabling starts at state 1
// - length 2 to 8 sets states used; last wraps to state 1
// - each state duration read by its own pointer, tenths of a second
// - rising step-forward moves to next state at once
// - rising step-back moves to previous state at once
// - force-first nonzero holds state 1
// - force-load loads low 3 bits of load value, below force-first
// - per-state outputs are one-hot on current state
// - phase index output is state number minus one
// - selectors pass input chosen by select low 3 bits to 313, 314
// - disabled selector passes its fallback value
// - each selector holds an execution rank 1 to 48
// - 24 constants live at points 320 to 343
// - every pointer is 0 to 511 and picks a point
`ifndef PLC_CFG_SVH
`define PLC_CFG_SVH
`define CLK_MHZ        20
`define SLOT_TIME_US   200
`define TENTH_TIME_MS  100
`define UNIT_COUNT     8'h30
`define PT_UNIT_BASE   9'h100
`define PT_SEQ         9'h138
`define PT_SEL1        9'h139
`define PT_SEL2        9'h13A
`define CFG_SEQ_BASE   8'hC0
`define CFG_SEL1_BASE  8'hCE
`define CFG_SEL2_BASE  8'hD9
`define SEQ_NEXT_OFS   8'h07
`define FN_ADD         6'h01
`define FN_MULDIV      6'h02
`define FN_SUB         6'h03
`define FN_AND         6'h04
`define FN_OR          6'h05
`define FN_NOT         6'h06
`define FN_GT          6'h07
`define FN_SWITCH      6'h08
`define FN_SEQ         6'h28
`define FN_SEL1        6'h29
`define FN_SEL2        6'h2A
`define REG_CTRL       3'h0
`define REG_COUNT      3'h1
`define REG_LEN        3'h2
`define REG_RANK1      3'h3
`define REG_RANK2      3'h4
`define REG_STATUS     3'h5
`define RST_COUNT      8'h32
`define RST_LEN        4'h8
`define RST_RANK       6'h01
`endif

// ---- include/plc_pkg.sv ----
/*
   types of the logic engine.
   assumes nothing beyond the config header.
*/
`default_nettype none
package plc_pkg;
   typedef logic signed [15:0] point_t;
   typedef enum logic [3:0] {
      S_IDLE    = 4'b0000,
      S_FN      = 4'b0001,
      S_FN_GET  = 4'b0010,
      S_PTR     = 4'b0011,
      S_PTR_GET = 4'b0100,
      S_PT_GET  = 4'b0101,
      S_CALC    = 4'b0110,
      S_WR      = 4'b0111,
      S_WR2     = 4'b1000,
      S_WAIT    = 4'b1001
   } engine_state_t;
endpackage
`default_nettype wire

// ---- hw/plc_mem.sv ----
/*
   single-port word memory with registered read data.
   assumes one user per cycle; the caller arbitrates.
*/
`default_nettype none
module plc_mem #(
   parameter int AW = 9,
   parameter int DW = 16
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata
);
   logic [DW-1:0] store [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (we) begin
         store[addr] <= wdata;
      end
      rdata <= store[addr];
   end
endmodule
`default_nettype wire

// ---- hw/plc_sequencer.sv ----
/*
   eight-state timed sequencer, evaluated once per host unit run.
   assumes eval pulses come from the engine with operands stable.
*/
`default_nettype none
`include "plc_cfg.svh"
module plc_sequencer
   import plc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        tick,
   input  wire logic        eval,
   input  wire logic        seq_on,
   input  wire logic [15:0] time_val,
   input  wire logic        step_fwd,
   input  wire logic        step_back,
   input  wire logic        force_first_phase,
   input  wire logic        force_load,
   input  wire logic [2:0]  load_phase_value,
   input  wire logic [3:0]  sequence_length,
   output logic [2:0]       phase_index_out,
   output logic [7:0]       phase_onehot,
   output logic             seq_active
);
   logic [15:0] elapsed;
   logic        fwd_prev;
   logic        back_prev;
   logic [2:0]  next_phase;
   logic [3:0]  len_c;
   wire  [2:0]  last  = 3'(len_c - 4'h1);
   wire  [2:0]  adv   = (phase_index_out >= last) ? 3'h0 : 3'(phase_index_out + 3'h1);
   wire  [2:0]  ret   = (phase_index_out == 3'h0) ? last : 3'(phase_index_out - 3'h1);
   wire  [15:0] t_min = (time_val == 16'h0000) ? 16'h0001 : time_val;
   wire         due   = elapsed >= t_min;

   assign len_c = (sequence_length < 4'h2) ? 4'h2 :
                  (sequence_length > 4'h8) ? 4'h8 : sequence_length;

   always_comb begin
      if (force_first_phase) begin
         next_phase = 3'h0;
      end else if (force_load) begin
         next_phase = load_phase_value;
      end else if (!seq_active) begin
         next_phase = 3'h0;
      end else if (step_fwd && !fwd_prev) begin
         next_phase = adv;
      end else if (step_back && !back_prev) begin
         next_phase = ret;
      end else if (due) begin
         next_phase = adv;
      end else begin
         next_phase = phase_index_out;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_index_out <= 3'h0;
         phase_onehot    <= 8'h00;
         seq_active      <= 1'b0;
         elapsed         <= 16'h0000;
         fwd_prev        <= 1'b0;
         back_prev       <= 1'b0;
      end else if (eval && !seq_on) begin
         phase_index_out <= 3'h0;
         phase_onehot    <= 8'h00;
         seq_active      <= 1'b0;
         elapsed         <= 16'h0000;
      end else if (eval) begin
         phase_index_out <= next_phase;
         phase_onehot    <= 8'h01 << next_phase;
         seq_active      <= 1'b1;
         fwd_prev        <= step_fwd;
         back_prev       <= step_back;
         if (next_phase != phase_index_out || !seq_active) begin
            elapsed <= 16'h0000;
         end
      end else if (tick && seq_active && elapsed != 16'hFFFF) begin
         elapsed <= 16'(elapsed + 16'h0001);
      end
   end
endmodule
`default_nettype wire

// ---- sim/plc_engine_properties.sv ----
/*
   port checks of the logic engine: bus handshake, enable, sequencer outputs.
   assumes it is bound into plc_engine; one clock, async high reset.
*/
`default_nettype none
module plc_engine_properties (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic [7:0]  phase_onehot,
   input wire logic [2:0]  phase_index_out,
   input wire logic        engine_enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire req     = wb_cyc_i && wb_stb_i;
   wire ctrl_wr = req && wb_we_i && wb_adr_i[11:2] == 10'h100 && wb_sel_i[1:0] == 2'b11;
   //////////////////////////////////////////////////
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_in_req: assert property (wb_ack_o |-> req)
      else $error("ack without a request");
   // engine may hold the bus off for one unit evaluation of up to 26 cycles, hence the wide bound
   a_ack_bounded: assert property ($rose(req) |-> ##[2:60] wb_ack_o)
      else $error("no ack in time");
   a_ack_after_take: assert property ($rose(wb_ack_o) |-> $past(req) && $past(req, 2))
      else $error("ack too early");
   a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read half not zero");
   a_enable_write: assert property (wb_ack_o && ctrl_wr |-> engine_enable == wb_dat_i[0])
      else $error("enable bit not written");
   a_enable_cause: assert property ($changed(engine_enable) |-> $past(ctrl_wr))
      else $error("enable changed without a write");
   a_phase_onehot: assert property ($onehot0(phase_onehot))
      else $error("state outputs not one-hot");
   a_phase_index: assert property (phase_onehot != 8'h00 |->
      phase_onehot == 8'h01 << phase_index_out)
      else $error("index does not match state");
   a_phase_off: assert property (phase_onehot == 8'h00 |-> phase_index_out == 3'h0)
      else $error("index not zero while off");
   a_idle_frozen: assert property (!engine_enable && !$past(engine_enable) &&
      !$past(engine_enable, 2) |-> $stable(phase_onehot))
      else $error("state moved while engine off");
   c_write: cover property (wb_ack_o && wb_we_i);
   c_third: cover property (phase_onehot == 8'h04);
   c_engine_on: cover property ($rose(engine_enable));
endmodule
bind plc_engine plc_engine_properties i_props (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phase_onehot(phase_onehot),
   .phase_index_out(phase_index_out), .engine_enable(engine_enable));
`default_nettype wire

// ---- sim/plc_ctl_model.sv ----
/*
   control structure model: classic wishbone master sharing the point bank.
   assumes the bench calls xfer; one transfer at a time.
*/
`default_nettype none
module plc_ctl_model (
   input  wire logic        clk,
   input  wire logic        ack,
   input  wire logic [31:0] rdat,
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic      [11:0] adr,
   output logic      [3:0]  sel,
   output logic      [31:0] wdat
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 12'h000;
      sel = 4'h0;
      wdat = 32'h0000_0000;
   end
   // released address and data lines show inverted values so stale data never looks valid
   task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d,
                       output logic [15:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      wdat <= {16'h0000, d};
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      adr <= ~a;
      wdat <= ~{16'h0000, d};
   endtask
endmodule
`default_nettype wire

// ---- sim/plc_engine_tb.sv ----
/*
   self-checking bench of the logic engine: registers, units, selectors, sequencer.
   assumes plc_ctl_model as bus master and a short tenth-second count.
*/
`default_nettype none
module plc_engine_tb
   import plc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        cyc, stb, we, ack, en;
   logic [11:0] adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   logic [7:0]  onehot;
   logic [2:0]  idx;
   int          errors = 0;
   int          total_checks = 0;
   int          cycles = 0;
   always #25 clk = ~clk;
   plc_engine #(.TENTH_CYC(50)) i_dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .phase_onehot(onehot), .phase_index_out(idx),
      .engine_enable(en));
   plc_ctl_model i_ctl (.clk(clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we),
      .adr(adr), .sel(sel), .wdat(wdat));
   //////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 100000) begin
         errors++;
         report_and_stop;
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string w);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t %s saw %h expected %h", $time, w, seen, exp);
      end
   endtask
   function automatic int pt(input int p);
      return 32'h800 + 4 * p;
   endfunction
   task automatic put(input int a, input int d);
      logic [15:0] q;
      i_ctl.xfer(1'b1, 12'(a), 16'(d), q);
   endtask
   task automatic get_chk(input int a, input int e, input string w);
      logic [15:0] q;
      i_ctl.xfer(1'b0, 12'(a), 16'h0000, q);
      chk(q, 16'(e), w);
   endtask
   task automatic unit(input int n, input int fn, input int a, input int b, input int c);
      put(16 * (n - 1), fn);
      put(16 * (n - 1) + 4, a);
      put(16 * (n - 1) + 8, b);
      put(16 * (n - 1) + 12, c);
   endtask
   // whole slots of 4000 clocks each; margin keeps writes clear of the fetch
   task automatic run(input int n);
      repeat (n * 4000 + 100) @(posedge clk);
   endtask
   // a fixed window may hold one or two evaluations; timed steps follow the change itself
   task automatic wait_step;
      logic [7:0] was;
      was = onehot;
      for (int n = 0; n < 9000 && onehot == was; n++) @(posedge clk);
   endtask
   task automatic state_chk(input int s, input string w);
      chk(16'(onehot), (s == 0) ? 16'h0000 : 16'h0001 << (s - 1), w);
      chk(16'(idx), (s == 0) ? 16'h0000 : 16'(s - 1), w);
      get_chk(pt(312), s, w);
      get_chk(pt(256), s, w);
   endtask
   //////////////////////////////////////////////////
   task automatic t_reset;
      chk(16'(en), 16'h0000, "enable port");
      get_chk(12'h400, 16'h0000, "ctrl");
      get_chk(12'h404, 16'h0032, "count");
      get_chk(12'h408, 16'h0008, "length");
      get_chk(12'h40C, 16'h0001, "rank one");
      put(12'h410, 16'h0030);
      get_chk(12'h410, 16'h0030, "rank two");
      put(12'h41C, 16'h1234);
      get_chk(12'h41C, 16'h0000, "unmapped");
      $display("reset test done");
   endtask
   task automatic t_units;
      put(pt(320), 5);
      put(pt(321), 7);
      put(pt(322), 1);
      put(pt(323), 0);
      put(pt(325), 16'h000A);
      for (int k = 0; k < 8; k++) begin
         put(pt(340 + k), 16'h0100 + k);
         put(4 * (209 + k), 340 + k);
      end
      put(4 * 206, 322);
      put(4 * 207, 325);
      put(4 * 208, 320);
      unit(1, 1, 320, 321, 0);
      unit(2, 1, 256, 320, 0);
      unit(3, 16'h0029, 0, 0, 0);
      unit(4, 1, 320, 320, 0);
      put(pt(256), 16'h0111);
      put(pt(259), 16'h0222);
      put(pt(314), 16'h0333);
      put(12'h404, 3);
      run(1);
      get_chk(pt(256), 16'h0111, "idle engine");
      put(12'h400, 1);
      run(3);
      get_chk(pt(256), 16'h000C, "unit sum");
      get_chk(pt(257), 16'h0011, "chained sum");
      get_chk(pt(313), 16'h0102, "selector pick");
      get_chk(pt(314), 16'h0333, "unhosted selector");
      get_chk(pt(259), 16'h0222, "skipped unit");
      put(4 * 206, 323);
      run(3);
      get_chk(pt(313), 16'h0005, "selector fallback");
      $display("unit test done");
   endtask
   task automatic t_seq;
      for (int k = 330; k < 336; k++) put(pt(k), (k == 334) ? 9 : 0);
      put(pt(324), 16'hFFFF);
      put(4 * 192, 330);
      for (int k = 193; k <= 200; k++) put(4 * k, 324);
      put(4 * 201, 331);
      put(4 * 202, 332);
      put(4 * 203, 335);
      put(4 * 204, 333);
      put(4 * 205, 334);
      unit(1, 16'h0028, 0, 0, 0);
      put(12'h404, 1);
      run(2);
      state_chk(0, "sequencer off");
      put(pt(330), 1);
      run(1);
      state_chk(1, "sequencer start");
      put(pt(331), 1);
      run(1);
      state_chk(2, "step forward");
      put(pt(331), 0);
      put(pt(332), 1);
      run(1);
      state_chk(1, "step back");
      put(12'h408, 3);
      put(pt(332), 0);
      run(1);
      put(pt(332), 1);
      run(1);
      state_chk(3, "back wrap");
      put(pt(332), 0);
      put(pt(331), 1);
      run(1);
      state_chk(1, "forward wrap");
      put(pt(333), 1);
      run(1);
      state_chk(2, "force load");
      put(pt(335), 1);
      run(1);
      state_chk(1, "force first");
      put(pt(324), 1);
      put(pt(333), 0);
      put(pt(335), 0);
      wait_step;
      state_chk(2, "timed step");
      wait_step;
      state_chk(3, "timed again");
      put(12'h400, 0);
      run(1);
      state_chk(3, "engine off");
      $display("sequencer test done");
   endtask
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_units;
      t_seq;
      report_and_stop;
   end
endmodule
`default_nettype wire
